/* timer_map.svh */
// Register offsets, field codes, reset values and divider counts for the
// compact timer. Assumes inclusion by the timer modules and testbench only.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Byte addresses of the word-aligned registers
`define OFS_CTRL_A   8'h00
`define OFS_CTRL_B   8'h04
`define OFS_CNT_LO   8'h08
`define OFS_CNT_HI   8'h0C
`define OFS_A_LO     8'h10
`define OFS_A_HI     8'h14
`define OFS_P_VAL    8'h18

// Reset value shared by every register byte
`define RST_BYTE     8'h00

// Mode field codes
`define MODE_CMP     2'h0
`define MODE_PWM     2'h2
`define MODE_CNT     2'h3

// Output action codes
`define ACT_NONE     2'h0
`define ACT_LOW      2'h1
`define ACT_HIGH     2'h2
`define ACT_TOGGLE   2'h3

// Clock select codes
`define CKS_SYS4     3'h0
`define CKS_SYS      3'h1
`define CKS_H16      3'h2
`define CKS_H64      3'h3
`define CKS_SUB_A    3'h4
`define CKS_SUB_B    3'h5
`define CKS_EXT_RISE 3'h6
`define CKS_EXT_FALL 3'h7

// Prescaler terminal counts for the divided internal clocks
`define DIV4_LAST    2'h3
`define DIV16_LAST   4'hF
`define DIV64_LAST   6'h3F

`endif

/* timer_pkg.sv */
// Types shared by the compact timer modules.
// Assumes timer_map.svh supplies the numeric constants.
package timer_pkg;

  // First control register, stored bits only
  typedef struct packed {
    logic       pause;
    logic [2:0] clk_sel;
    logic       on;
  } ctrl_a_s;

  // Second control register, laid out as on the bus
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] action;
    logic       oc;
    logic       pol;
    logic       swap;
    logic       clr_sel;
  } ctrl_b_s;

  // Bus slave phase
  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD1, BUS_RD2} bus_e;

  // Whole state of the timer core
  typedef struct packed {
    ctrl_a_s     ca;
    ctrl_b_s     cb;
    logic [15:0] cmp_a;
    logic [7:0]  cmp_p;
    logic [15:0] cnt;
    logic [7:0]  buf_b;
    logic        on_prev;
    bus_e        bus;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic        fa;
    logic        fp;
  } timer_state_s;

endpackage

/* timer_tick_gen.sv */
// Timer clock enable generator: divided internal rates and external edges.
// Assumes one system clock; the external pin is asynchronous to it.
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_tick_gen #(
  parameter int unsigned SUB_DIV = 1526
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] clk_sel,
  input  wire logic       ext_pin,
  output logic            tick
);
  typedef struct packed {
    logic [5:0]  pre;
    logic [15:0] sub;
    logic [2:0]  sync;
  } tick_state_s;

  tick_state_s st;
  tick_state_s nxt;
  logic        sub_hit;

  // Sub clock is a divided enable since there is only one clock
  assign sub_hit = (st.sub == 16'(SUB_DIV - 1));

  // Prescalers run freely so a select change needs no restart
  always_comb begin
    nxt      = st;
    nxt.pre  = st.pre + 6'h01;
    nxt.sub  = sub_hit ? 16'h0000 : st.sub + 16'h0001;
    nxt.sync = {st.sync[1:0], ext_pin};
    case (clk_sel)
      `CKS_SYS4:     tick = (st.pre[1:0] == `DIV4_LAST);
      `CKS_SYS:      tick = 1'b1;
      `CKS_H16:      tick = (st.pre[3:0] == `DIV16_LAST);
      `CKS_H64:      tick = (st.pre == `DIV64_LAST);
      `CKS_EXT_RISE: tick = st.sync[1] & ~st.sync[2];
      `CKS_EXT_FALL: tick = ~st.sync[1] & st.sync[2];
      default:       tick = sub_hit;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end
endmodule

/* timer_pin_drive.sv */
// Output pin stage: compare-match level, PWM shaping and polarity.
// Assumes match and on-rise events arrive as one-cycle pulses.
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_pin_drive
  import timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire ctrl_b_s     ctrl,
  input  wire logic        on_rise,
  input  wire logic        match_a,
  input  wire logic [15:0] cnt,
  input  wire logic [16:0] duty,
  output logic             pin
);
  typedef struct packed {
    logic level;
    logic pin;
  } pin_state_s;

  pin_state_s st;
  pin_state_s nxt;
  logic       active;
  logic       raw;

  // Duty at or above the period keeps the output active all the time
  assign active = ({1'b0, cnt} < duty);

  always_comb begin
    nxt = st;
    if (on_rise) begin
      nxt.level = ctrl.oc;
    end else if (match_a && ctrl.mode != `MODE_PWM) begin
      case (ctrl.action)
        `ACT_LOW:    nxt.level = 1'b0;
        `ACT_HIGH:   nxt.level = 1'b1;
        `ACT_TOGGLE: nxt.level = ~st.level;
        default:     nxt.level = st.level;
      endcase
    end
    case (ctrl.action)
      `ACT_LOW:  raw = ctrl.oc;
      `ACT_HIGH: raw = active ? ctrl.oc : ~ctrl.oc;
      default:   raw = ~ctrl.oc;
    endcase
    if (ctrl.mode == `MODE_CNT) begin
      nxt.pin = 1'b0;
    end else if (ctrl.mode == `MODE_PWM) begin
      nxt.pin = raw ^ ctrl.pol;
    end else begin
      nxt.pin = nxt.level ^ ctrl.pol;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign pin = st.pin;

  // Toggle action inverts the held level on each comparator A match
  toggle_level_a: assert property (@(posedge clk) disable iff (rst)
    match_a && !on_rise && ctrl.mode == `MODE_CMP
    && ctrl.action == `ACT_TOGGLE |=> st.level == !$past(st.level))
    else $error("toggle action did not invert the level");

  on_initial_a: assert property (@(posedge clk) disable iff (rst)
    on_rise && ctrl.mode == `MODE_CMP
    |=> pin == ($past(ctrl.oc) ^ $past(ctrl.pol)))
    else $error("pin not at initial level after switch on");
endmodule

/* compact_timer_pwm_regs.sv */
// Compact 16-bit timer with compare A, compare P, PWM and AHB-Lite registers.
// Assumes a single AHB-Lite master and one system clock; the external
// clock pin is asynchronous and synchronised in the tick generator.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "timer_map.svh"

// Operation
// - Pause holds the count, resumes from it
// - Clock select picks the counter clock source
// - Counter runs only while switched on
// - Switching on clears the counter
// - Switching on restores initial pin level
// - Mode field selects compare, PWM or counter
// - Compare A match applies output action
// - PWM action forces or passes waveform
// - Level bit gives initial or active level
// - Polarity bit inverts pin outside counter mode
// - Swap bit exchanges period and duty roles
// - Clear select picks clearing comparator
// - P value zero clears on overflow
// - Counter readable as low and high bytes
// - Compare A held as two bytes
// - P compares counter top byte, 256 steps
// - Pin unused in counter mode
// - Low three control bits read zero
// - Low bytes pass through shared buffer
// - Clear select zero raises both flags
// - Clear select one never raises P flag outside PWM mode
module compact_timer_pwm_regs
  import timer_pkg::*;
#(
  parameter int unsigned SUB_DIV = 1526
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        external_clock_pin,
  output logic             timer_output_pin,
  output logic             match_a_flag,
  output logic             match_p_flag
);
  import timer_pkg::*;

  timer_state_s st;
  timer_state_s nxt;
  logic         tick;
  logic         on_rise;
  logic         run;
  logic [15:0]  inc;
  logic         hit_a;
  logic         hit_p;
  logic         pwm_mode;
  logic         clr;
  logic         flag_p;
  logic [16:0]  duty;
  logic         accept;
  logic [31:0]  rd_val;

  // Clock source selection and external edge detection
  timer_tick_gen #(
    .SUB_DIV (SUB_DIV)
  ) u_tick (
    .clk     (clk),
    .rst     (rst),
    .clk_sel (st.ca.clk_sel),
    .ext_pin (external_clock_pin),
    .tick    (tick)
  );

  // Pin shaping lives apart so the core only supplies events
  timer_pin_drive u_pin (
    .clk     (clk),
    .rst     (rst),
    .ctrl    (st.cb),
    .on_rise (on_rise),
    .match_a (run & hit_a),
    .cnt     (st.cnt),
    .duty    (duty),
    .pin     (timer_output_pin)
  );

  // Switch-on edge and counting qualifier
  assign on_rise  = st.ca.on & ~st.on_prev;
  assign run      = tick & st.ca.on & ~st.ca.pause & ~on_rise;
  assign inc      = st.cnt + 16'h0001;
  assign pwm_mode = (st.cb.mode == `MODE_PWM);

  // Comparator A; a zero value never matches, the counter just overflows
  assign hit_a = (st.cmp_a != 16'h0000) && (inc == st.cmp_a);

  // Comparator P sees only the top byte; zero means overflow at the top
  always_comb begin
    if (st.cmp_p == 8'h00) begin
      hit_p = (st.cnt == 16'hFFFF);
    end else begin
      hit_p = (inc[15:8] == st.cmp_p) && (inc[7:0] == 8'h00);
    end
  end

  // Clear source and P flag depend on mode, swap and clear select
  always_comb begin
    if (pwm_mode) begin
      clr    = st.cb.swap ? hit_a : hit_p;
      flag_p = hit_p;
    end else begin
      clr    = st.cb.clr_sel ? hit_a : hit_p;
      flag_p = hit_p & ~st.cb.clr_sel;
    end
  end

  // Duty threshold; a zero P value as duty stands for the full 65536
  always_comb begin
    if (st.cb.swap) begin
      duty = {(st.cmp_p == 8'h00), st.cmp_p, 8'h00};
    end else begin
      duty = {1'b0, st.cmp_a};
    end
  end

  // Address phase is taken only when the bus is ready
  assign accept = hsel & htrans[1] & hready;

  // Read value for the latched address
  always_comb begin
    if (st.addr == `OFS_CTRL_A) begin
      rd_val = {24'h000000, st.ca, 3'h0};
    end else if (st.addr == `OFS_CTRL_B) begin
      rd_val = {24'h000000, st.cb};
    end else if (st.addr == `OFS_CNT_LO) begin
      rd_val = {24'h000000, st.buf_b};
    end else if (st.addr == `OFS_CNT_HI) begin
      rd_val = {24'h000000, st.cnt[15:8]};
    end else if (st.addr == `OFS_A_LO) begin
      rd_val = {24'h000000, st.buf_b};
    end else if (st.addr == `OFS_A_HI) begin
      rd_val = {24'h000000, st.cmp_a[15:8]};
    end else if (st.addr == `OFS_P_VAL) begin
      rd_val = {24'h000000, st.cmp_p};
    end else begin
      rd_val = 32'h00000000;
    end
  end

  // Next state: counter, flags and bus slave
  always_comb begin
    nxt         = st;
    nxt.on_prev = st.ca.on;
    nxt.fa      = 1'b0;
    nxt.fp      = 1'b0;
    if (on_rise) begin
      nxt.cnt = 16'h0000;
    end else if (run) begin
      nxt.cnt = clr ? 16'h0000 : inc;
      nxt.fa  = hit_a;
      nxt.fp  = flag_p;
    end
    case (st.bus)
      BUS_WR: begin
        // Writes land at the end of the data phase
        nxt.bus = BUS_IDLE;
        if (st.addr == `OFS_CTRL_A) begin
          nxt.ca = hwdata[7:3];
        end else if (st.addr == `OFS_CTRL_B) begin
          nxt.cb = hwdata[7:0];
        end else if (st.addr == `OFS_A_LO) begin
          nxt.buf_b = hwdata[7:0];
        end else if (st.addr == `OFS_A_HI) begin
          nxt.cmp_a = {hwdata[7:0], st.buf_b};
        end else if (st.addr == `OFS_P_VAL) begin
          nxt.cmp_p = hwdata[7:0];
        end
      end
      BUS_RD1: begin
        // A high-byte read snapshots its low byte for the next read
        nxt.bus   = BUS_RD2;
        nxt.rdata = rd_val;
        if (st.addr == `OFS_CNT_HI) begin
          nxt.buf_b = st.cnt[7:0];
        end else if (st.addr == `OFS_A_HI) begin
          nxt.buf_b = st.cmp_a[7:0];
        end
      end
      default: begin
        nxt.bus = BUS_IDLE;
      end
    endcase
    if (accept) begin
      nxt.addr = haddr[7:0];
      nxt.bus  = hwrite ? BUS_WR : BUS_RD1;
    end
  end

  // One register for all state keeps reset values in one place
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  // Reads take one wait state so a write just before is visible
  assign hreadyout    = (st.bus != BUS_RD1);
  assign hrdata       = st.rdata;
  assign hresp        = 1'b0;
  assign match_a_flag = st.fa;
  assign match_p_flag = st.fp;

  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (rst);

  pause_hold_a: assert property (
    st.ca.pause && st.ca.on && st.on_prev |=> st.cnt == $past(st.cnt))
    else $error("counter moved while paused");

  off_hold_a: assert property (
    !st.ca.on |=> st.cnt == $past(st.cnt))
    else $error("counter moved while switched off");

  on_clear_a: assert property (
    on_rise |=> st.cnt == 16'h0000)
    else $error("counter not cleared on switch on");

  ctrl_low_a: assert property (
    st.bus == BUS_RD2 && st.addr == `OFS_CTRL_A |-> hrdata[2:0] == 3'h0)
    else $error("unimplemented control bits read nonzero");

  buf_copy_a: assert property (
    st.bus == BUS_WR && st.addr == `OFS_A_HI
    |=> st.cmp_a == {$past(hwdata[7:0]), $past(st.buf_b)})
    else $error("high byte write did not copy the buffer");

  p_clear_a: assert property (
    run && hit_p && !pwm_mode && !st.cb.clr_sel |=> st.cnt == 16'h0000)
    else $error("comparator P match did not clear the counter");

  no_pflag_a: assert property (
    !pwm_mode && st.cb.clr_sel |=> !match_p_flag)
    else $error("P flag raised with clear select high");

  count_step_a: assert property (
    run && !clr |=> st.cnt == 16'($past(st.cnt) + 16'h0001))
    else $error("counter did not step by one");

  cnt_high_a: assert property (
    st.bus == BUS_RD1 && st.addr == `OFS_CNT_HI
    |=> hrdata == {24'h000000, $past(st.cnt[15:8])}
    ##0 st.buf_b == $past(st.cnt[7:0]))
    else $error("counter high read or snapshot wrong");

  // Match flags pulse the cycle after a counted match, P only in PWM mode or with clear select zero
  flag_a_pulse_a: assert property (
    run && hit_a |=> match_a_flag)
    else $error("match A flag did not pulse");

  flag_p_pulse_a: assert property (
    run && hit_p && (pwm_mode || !st.cb.clr_sel) |=> match_p_flag)
    else $error("match P flag did not pulse");

  // Clear sources outside PWM mode, and the wrap at the top
  a_clear_a: assert property (
    run && hit_a && !pwm_mode && st.cb.clr_sel |=> st.cnt == 16'h0000)
    else $error("comparator A match did not clear the counter");

  top_wrap_a: assert property (
    run && st.cnt == 16'hFFFF |=> st.cnt == 16'h0000)
    else $error("counter did not wrap to zero at the top");

  // PWM period comes from P unless the roles are swapped
  pwm_period_a: assert property (
    run && pwm_mode && !st.cb.swap && hit_p |=> st.cnt == 16'h0000)
    else $error("PWM period did not end on comparator P");

  pwm_swap_a: assert property (
    run && pwm_mode && st.cb.swap && hit_a |=> st.cnt == 16'h0000)
    else $error("swapped PWM period did not end on comparator A");

  // Without a tick the counter stands unless switched on, whatever else the bus does
  tick_only_a: assert property (
    !tick && !on_rise |=> st.cnt == $past(st.cnt))
    else $error("counter moved without a tick");

  // Count bytes are read only; a write must not disturb the count
  count_ro_a: assert property (
    st.bus == BUS_WR && !run && !on_rise
    && (st.addr == `OFS_CNT_LO || st.addr == `OFS_CNT_HI)
    |=> st.cnt == $past(st.cnt))
    else $error("count byte write moved the counter");

  // Register writes land with the data phase value
  mode_write_a: assert property (
    st.bus == BUS_WR && st.addr == `OFS_CTRL_B
    |=> st.cb == $past(hwdata[7:0]))
    else $error("second control register write lost");

  p_write_a: assert property (
    st.bus == BUS_WR && st.addr == `OFS_P_VAL
    |=> st.cmp_p == $past(hwdata[7:0]))
    else $error("comparator P write lost");

  // Low bytes only ever travel through the shared buffer
  buf_load_a: assert property (
    st.bus == BUS_WR && st.addr == `OFS_A_LO
    |=> st.buf_b == $past(hwdata[7:0]))
    else $error("low byte write missed the buffer");

  low_read_a: assert property (
    st.bus == BUS_RD1
    && (st.addr == `OFS_CNT_LO || st.addr == `OFS_A_LO)
    |=> hrdata == {24'h000000, $past(st.buf_b)})
    else $error("low byte read did not return the buffer");

  // A high read also parks the low byte for the next low read
  a_high_a: assert property (
    st.bus == BUS_RD1 && st.addr == `OFS_A_HI
    |=> hrdata == {24'h000000, $past(st.cmp_a[15:8])}
    ##0 st.buf_b == $past(st.cmp_a[7:0]))
    else $error("compare A high read or snapshot wrong");

  pwm_run_c: cover property (
    pwm_mode && run && clr ##1 match_p_flag || match_a_flag);

  ext_tick_c: cover property (
    st.ca.clk_sel == `CKS_EXT_RISE && run ##1 st.ca.on);

  pair_read_c: cover property (
    st.bus == BUS_RD2 && st.addr == `OFS_CNT_HI
    ##[1:8] st.bus == BUS_RD2 && st.addr == `OFS_CNT_LO);

  // Switch-on in PWM mode and a tick swallowed by pause
  pwm_on_c: cover property (
    on_rise && pwm_mode);

  pause_tick_c: cover property (
    st.ca.on && st.ca.pause && tick);
endmodule

/* tb_top.sv */
// Self-checking bench for the compact timer: registers, clocks, pin, PWM.
// Assumes the offsets of timer_map.svh and the hand-over AHB-Lite timing.
`timescale 1ns/1ps
`include "timer_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pin;
  logic        fa;
  logic        fp;
  logic        ext = 1'b0;
  logic        ext_div = 1'b0;
  logic        ext_pin;
  logic        ext_run = 1'b0;
  logic [1:0]  ediv = 2'h0;
  logic        rd_dp = 1'b0;
  logic [7:0]  e_q;
  logic [7:0]  q [$];
  int          n_fail = 0;
  int          checks_done = 0;
  int          seed = 45;
  int          fac [8] = '{4, 1, 16, 64, 4, 4, 8, 8};
  logic [7:0]  ofs [8] = '{`OFS_CTRL_A, `OFS_CTRL_B, `OFS_CNT_LO,
    `OFS_CNT_HI, `OFS_A_LO, `OFS_A_HI, `OFS_P_VAL, 8'h1C};

  // Sub clock shortened to every fourth cycle to keep the run brief
  compact_timer_pwm_regs #(.SUB_DIV(4)) u_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .external_clock_pin(ext_pin), .timer_output_pin(pin),
    .match_a_flag(fa), .match_p_flag(fp));

  // System clock, 20 ns period
  initial begin
    forever #10 clk = ~clk;
  end

  // External count clock, eight system cycles a period, while enabled
  always @(posedge clk) begin
    if (ext_run) begin
      ediv <= ediv + 2'h1;
      if (ediv == 2'h3) begin
        ext_div <= ~ext_div;
      end
    end
  end

  // Free-running source while enabled, hand-made pulses otherwise
  assign ext_pin = ext_run ? ext_div : ext;

  // Read data checked against the oldest queued note when the phase ends
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      e_q = q.pop_front();
      `CHK("hrdata", {24'h0, e_q}, hrdata)
      `CHK("hresp", 1'b0, hresp)
    end
  end

  // One single transfer; the master waits on hready, never on a count
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rd_dp  <= ~w;
    if (!w) q.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, e);
    bus(1'b0, a, e);
  endtask

  // High byte first so the low byte comes through the shared buffer
  task automatic rdc(input logic [15:0] c);
    rd(`OFS_CNT_HI, c[15:8]);
    rd(`OFS_CNT_LO, c[7:0]);
  endtask

  task automatic set_a(input logic [15:0] v);
    wr(`OFS_A_LO, v[7:0]);
    wr(`OFS_A_HI, v[15:8]);
  endtask

  // Edges are held four cycles, well past the input synchroniser
  task automatic pulse(input int k);
    repeat (k) begin
      ext <= 1'b1;
      repeat (4) @(posedge clk);
      ext <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // Cycles between two consecutive pulses of one match flag
  task automatic gap(input logic sel_p, output int g);
    g = 0;
    do @(posedge clk); while ((sel_p ? fp : fa) !== 1'b1);
    do begin
      @(posedge clk);
      g++;
    end while ((sel_p ? fp : fa) !== 1'b1);
  endtask

  // Count cycles with the pin high and pulses of the P flag
  task automatic watch(input int n, output int hi, output int np);
    hi = 0;
    np = 0;
    repeat (n) begin
      @(posedge clk);
      hi += int'(pin === 1'b1);
      np += int'(fp === 1'b1);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    int         g;
    int         hi;
    int         np;
    int         k;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] b;
    logic       lv;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(`OFS_CTRL_A, 8'hFF);
    rd(`OFS_CTRL_A, 8'hF8);
    wr(`OFS_CTRL_A, 8'h00);
    v = 8'($random(seed));
    w = 8'($random(seed));
    wr(`OFS_CTRL_B, v);
    rd(`OFS_CTRL_B, v);
    wr(`OFS_CNT_HI, 8'hAA);
    rd(`OFS_CNT_HI, 8'h00);
    set_a({w, v});
    rd(`OFS_A_HI, w);
    rd(`OFS_A_LO, v);
    wr(`OFS_P_VAL, w);
    rd(`OFS_P_VAL, w);
    // Counting on external rising edges: pause, off and switch-on
    set_a(16'h0000);
    wr(`OFS_CTRL_B, 8'h01);
    wr(`OFS_CTRL_A, 8'h68);
    k = 3 + int'($unsigned($random(seed)) % 5);
    pulse(k);
    rdc(16'(k));
    wr(`OFS_CTRL_A, 8'hE8);
    pulse(3);
    rdc(16'(k));
    wr(`OFS_CTRL_A, 8'h68);
    pulse(2);
    rdc(16'(k + 2));
    wr(`OFS_CTRL_A, 8'h60);
    pulse(2);
    rdc(16'(k + 2));
    wr(`OFS_CTRL_A, 8'h68);
    rdc(16'h0000);
    // Every clock source in counter mode, match A period of three ticks
    wr(`OFS_CTRL_A, 8'h00);
    set_a(16'h0003);
    wr(`OFS_CTRL_B, 8'hC1);
    ext_run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_CTRL_A, {1'b0, 3'(c), 4'h8});
      gap(1'b0, g);
      `CHK("a period", fac[c] * 3, g)
      `CHK("pin off", 1'b0, pin)
      wr(`OFS_CTRL_A, 8'h00);
    end
    ext_run <= 1'b0;
    // Compare mode pin: initial level, action on match, polarity
    for (int i = 0; i < 8; i++) begin
      b = {2'h0, 2'(i), ~1'(i >> 1), 1'(i >> 2), 2'h1};
      lv = (b[5:4] == 2'h0) ? b[3] : (b[5:4] == 2'h3) ? ~b[3] : ~b[4];
      wr(`OFS_CTRL_A, 8'h00);
      wr(`OFS_CTRL_B, b);
      wr(`OFS_CTRL_A, 8'h08);
      repeat (2) @(posedge clk);
      `CHK("pin init", b[3] ^ b[2], pin)
      do @(posedge clk); while (fa !== 1'b1);
      `CHK("pin match", lv ^ b[2], pin)
      do @(posedge clk); while (fa !== 1'b1);
      `CHK("pin next", (b[5:4] == 2'h3 ? b[3] : lv) ^ b[2], pin)
    end
    // Clear on P with both flags, then clear on A with no P flag
    wr(`OFS_CTRL_A, 8'h00);
    wr(`OFS_P_VAL, 8'h01);
    wr(`OFS_CTRL_B, 8'h00);
    wr(`OFS_CTRL_A, 8'h18);
    gap(1'b1, g);
    `CHK("p period", 256, g)
    gap(1'b0, g);
    `CHK("a period", 256, g)
    // A beyond P so the count passes P*256 while clearing on A
    set_a(16'h0200);
    wr(`OFS_CTRL_B, 8'h01);
    watch(600, hi, np);
    `CHK("p flags", 0, np)
    // PWM: period P*256, duty A, actions and levels, timer off to change
    set_a(16'h0040);
    for (int i = 0; i < 6; i++) begin
      b = {2'h2, 2'(i % 3), 1'(i < 3), 1'(i == 4 || i == 2), 2'h0};
      wr(`OFS_CTRL_A, 8'h00);
      wr(`OFS_CTRL_B, b);
      wr(`OFS_CTRL_A, 8'h18);
      repeat (300) @(posedge clk);
      watch(256, hi, np);
      k = (b[5:4] == 2'h0) ? 0 : (b[5:4] == 2'h1) ? 256 : 64;
      k = (b[3] ^ b[2]) ? k : 256 - k;
      `CHK("pwm high", k, hi)
    end
    // Swapped roles: period from A, duty from P
    wr(`OFS_CTRL_A, 8'h00);
    set_a(16'h0200);
    wr(`OFS_CTRL_B, 8'hAA);
    wr(`OFS_CTRL_A, 8'h18);
    repeat (600) @(posedge clk);
    watch(512, hi, np);
    `CHK("swap high", 256, hi)
    final_report();
  end
endmodule
